// ===== design/ebh_pkg.sv
package ebh_pkg;
  localparam int unsigned ADDR_W        = 20;
  localparam int unsigned LOW_ADDR_W    = 16;
  localparam int unsigned DATA_W        = 16;
  localparam int unsigned WAIT_W        = 3;
  localparam logic [2:0]  WAIT_READY_MIN = 3'h2;
  localparam logic [ADDR_W-1:0] ROM_BASE = 20'h0f000;
  localparam logic [ADDR_W-1:0] ROM_TOP  = 20'h0ffff;
  localparam logic        MODE_RESET_VAL = 1'b0;

  typedef enum logic [1:0] {
    EBH_SP_DATA,
    EBH_SP_PROG,
    EBH_SP_IO
  } ebh_space_t;

  typedef enum logic [2:0] {
    EBH_IDLE,
    EBH_WAIT,
    EBH_READY,
    EBH_HOLD
  } ebh_state_t;
endpackage

// ===== design/ebh_bus_if.sv
// Behaviour
// - Each space select idles high and goes low only during an external access to its space.
// - The space selects float in hold and while the float input is low.
// - The memory strobe goes low for any external access whose space code is not I/O.
// - The I/O strobe goes low only for an external I/O access.
// - Read/write idles high and goes low only during a write.
// - Strobes and read/write float in hold and while the float input is low.
// - A low READY sampled at the end of waits adds a cycle and READY is sampled again.
// - READY is only honoured when at least two wait states are programmed.
// - READY is not sampled before all programmed wait states have passed.
// - A hold request is granted and then address, data and control lines float.
// - Hold acknowledge is high while in hold with the bus floated, and floats with the float input.
// - Mode pin low at reset maps the ROM into the top 4K words of the low 64K of program space.
// - Mode pin high at reset removes the ROM so those addresses go external.
// - The mode pin is sampled only in reset and a status bit may override it.
// - Address floats in hold or float; upper four lines carry program addresses only.
// - With two or more waits the wait-done output goes low at the first wait and high at the last.
`timescale 1ns/10ps
`default_nettype none
module ebh_bus_if
  import ebh_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              rst_b,
  input  wire logic              clk_en,
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire logic [1:0]        req_space,
  input  wire logic              req_write,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0] req_wdata,
  input  wire logic [WAIT_W-1:0] req_waits,
  output logic                   rsp_valid,
  output logic [DATA_W-1:0]      rsp_rdata,
  output logic                   rom_hit,
  input  wire logic              mode_ovr_we,
  input  wire logic              mode_ovr_val,
  output logic                   rom_map_mode_sel,
  input  wire logic              reset_active,
  input  wire logic              mode_pin,
  input  wire logic              ready_in,
  input  wire logic              hold_req_n,
  input  wire logic              float_n,
  output logic                   data_space_sel_n,
  output logic                   program_space_sel_n,
  output logic                   io_space_sel_n,
  output logic                   sel_oe,
  output logic                   memory_strobe_n,
  output logic                   io_device_strobe_n,
  output logic                   rd_wr_n,
  output logic                   ctl_oe,
  output logic                   bus_release_ack,
  output logic                   ack_oe,
  output logic [ADDR_W-1:0]      addr_o,
  output logic                   addr_oe,
  output logic [DATA_W-1:0]      data_o,
  output logic                   data_oe,
  input  wire logic [DATA_W-1:0] data_i,
  output logic                   wait_states_done_n,
  output logic                   msc_oe
);

  ebh_state_t        st_q, st_d;
  logic [WAIT_W-1:0] wcnt_q, wcnt_d, wtot_q, wtot_d;
  logic [1:0]        sp_q, sp_d;
  logic              wr_q, wr_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [DATA_W-1:0] wd_q, wd_d, rd_q, rd_d;
  logic              rv_q, rv_d;
  logic              mode_q, mode_d;
  logic              msc_q, msc_d;
  logic              in_hold, floated, active, rom_now;

  function automatic logic rom_decode(input logic [1:0] sp, input logic [ADDR_W-1:0] a,
                                      input logic mp);
    rom_decode = !mp && (sp == EBH_SP_PROG) && (a >= ROM_BASE) && (a <= ROM_TOP);
  endfunction

  assign rom_now  = rom_decode(req_space, req_addr, mode_q);
  assign in_hold  = (st_q == EBH_HOLD);
  assign floated  = in_hold || !float_n;
  assign active   = (st_q == EBH_WAIT) || (st_q == EBH_READY);
  assign req_ready = (st_q == EBH_IDLE) && hold_req_n && !reset_active;
  assign rom_hit  = rom_now;
  assign rom_map_mode_sel = mode_q;

  always_comb begin
    st_d   = st_q;
    wcnt_d = wcnt_q;
    wtot_d = wtot_q;
    sp_d   = sp_q;
    wr_d   = wr_q;
    addr_d = addr_q;
    wd_d   = wd_q;
    rd_d   = rd_q;
    rv_d   = 1'b0;
    msc_d  = msc_q;
    mode_d = mode_q;
    if (reset_active) begin
      mode_d = mode_pin;
    end else if (mode_ovr_we) begin
      mode_d = mode_ovr_val;
    end
    unique case (st_q)
      EBH_IDLE: begin
        if (!hold_req_n) begin
          st_d = EBH_HOLD;
        end else if (req_valid && !reset_active && !rom_now) begin
          st_d   = EBH_WAIT;
          sp_d   = req_space;
          wr_d   = req_write;
          addr_d = req_addr;
          wd_d   = req_wdata;
          wcnt_d = req_waits;
          wtot_d = req_waits;
          msc_d  = (req_waits >= WAIT_READY_MIN) ? 1'b0 : 1'b1;
        end
      end
      EBH_WAIT: begin
        if (wcnt_q != '0) begin
          wcnt_d = wcnt_q - 3'h1;
          if (wcnt_q == 3'h2) begin
            msc_d = 1'b1;
          end
        end else if (wtot_q >= WAIT_READY_MIN && !ready_in) begin
          st_d = EBH_READY;
        end else begin
          st_d = EBH_IDLE;
          rv_d = 1'b1;
          rd_d = data_i;
          msc_d = 1'b1;
        end
      end
      EBH_READY: begin
        if (ready_in) begin
          st_d = EBH_IDLE;
          rv_d = 1'b1;
          rd_d = data_i;
        end
      end
      EBH_HOLD: begin
        if (hold_req_n) begin
          st_d = EBH_IDLE;
        end
      end
      default: st_d = EBH_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q   <= EBH_IDLE;
      wcnt_q <= '0;
      wtot_q <= '0;
      sp_q   <= 2'h0;
      wr_q   <= 1'b0;
      addr_q <= '0;
      wd_q   <= '0;
      rd_q   <= '0;
      rv_q   <= 1'b0;
      msc_q  <= 1'b1;
      mode_q <= MODE_RESET_VAL;
    end else if (clk_en) begin
      st_q   <= st_d;
      wcnt_q <= wcnt_d;
      wtot_q <= wtot_d;
      sp_q   <= sp_d;
      wr_q   <= wr_d;
      addr_q <= addr_d;
      wd_q   <= wd_d;
      rd_q   <= rd_d;
      rv_q   <= rv_d;
      msc_q  <= msc_d;
      mode_q <= mode_d;
    end
  end

  // One space code per access, so at most one select can be low
  assign data_space_sel_n    = !(active && sp_q == EBH_SP_DATA);
  assign program_space_sel_n = !(active && sp_q == EBH_SP_PROG);
  assign io_space_sel_n      = !(active && sp_q == EBH_SP_IO);
  assign sel_oe              = !floated;
  assign memory_strobe_n     = !(active && sp_q != EBH_SP_IO);
  assign io_device_strobe_n  = !(active && sp_q == EBH_SP_IO);
  assign rd_wr_n             = !(active && wr_q);
  assign ctl_oe              = !floated;
  assign bus_release_ack     = in_hold;
  assign ack_oe              = float_n;
  // Upper lines only carry program addresses
  assign addr_o  = (sp_q == EBH_SP_PROG) ? addr_q
                 : {{(ADDR_W-LOW_ADDR_W){1'b0}}, addr_q[LOW_ADDR_W-1:0]};
  assign addr_oe = !floated;
  assign data_o  = wd_q;
  assign data_oe = active && wr_q && !floated;
  assign wait_states_done_n = msc_q;
  assign msc_oe    = float_n;
  assign rsp_valid = rv_q;
  assign rsp_rdata = rd_q;

  one_sel_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $onehot0({!data_space_sel_n, !program_space_sel_n, !io_space_sel_n}))
    else $error("more than one space select low");
  hold_float_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    bus_release_ack |-> !sel_oe && !ctl_oe && !addr_oe && !data_oe)
    else $error("bus driven in hold");
  ctl_float_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !float_n |-> !ctl_oe && !ack_oe && !sel_oe) else $error("outputs driven while float");
  memory_strobe_n_io_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !memory_strobe_n |-> io_device_strobe_n) else $error("both strobes low");
  io_device_strobe_n_sel_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !io_device_strobe_n |-> !io_space_sel_n) else $error("io strobe without io select");
  write_dir_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !rd_wr_n |-> !memory_strobe_n || !io_device_strobe_n)
    else $error("write low outside access");
  ready_wait_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && st_q == EBH_READY && !ready_in |=> st_q == EBH_READY)
    else $error("left ready wait while not ready");
  ready_ignore_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    st_q == EBH_READY |-> wtot_q >= WAIT_READY_MIN) else $error("ready honoured with few waits");
  ready_late_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && st_q == EBH_WAIT && wcnt_q != '0 |=> st_q == EBH_WAIT)
    else $error("ready sampled before waits done");
  rom_map_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    req_valid && req_ready && rom_now |=> st_q == EBH_IDLE)
    else $error("rom access went external");
  mode_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && !reset_active && !mode_ovr_we |=> $stable(mode_q))
    else $error("mode changed outside reset");
  msc_first_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && st_q == EBH_IDLE && st_d == EBH_WAIT && req_waits >= WAIT_READY_MIN
    |=> !wait_states_done_n) else $error("wait done not asserted");
  hold_ack_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && st_q == EBH_IDLE && !hold_req_n |=> bus_release_ack)
    else $error("hold not granted");
endmodule
`default_nettype wire

// ===== tb/ebh_ext_mem.sv
`timescale 1ns/10ps
`default_nettype none
module ebh_ext_mem
  import ebh_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              memory_strobe_n,
  input  wire logic              io_device_strobe_n,
  input  wire logic              rd_wr_n,
  input  wire logic [ADDR_W-1:0] addr_o,
  input  wire logic [3:0]        lo_len,
  output logic                   ready_in,
  output logic [DATA_W-1:0]      data_i
);
  logic [3:0]        cnt_q = 4'h0;
  logic [DATA_W-1:0] last_q = 16'h0000;
  logic              act;
  assign act = !memory_strobe_n || !io_device_strobe_n;
  always @(posedge sys_clk) begin
    cnt_q <= act ? cnt_q + 4'h1 : 4'h0;
    last_q <= data_i;
  end
  // Busy for the first lo_len cycles of each access
  assign ready_in = !(act && cnt_q < lo_len);
  // Released bus flips every cycle so stale data cannot pass
  assign data_i = (act && rd_wr_n) ? addr_o[15:0] ^ 16'h5a5a : ~last_q;
endmodule
`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  import ebh_pkg::*;
  logic              sys_clk = 0, rst_b = 0, req_valid = 0, req_write = 0;
  logic              mode_ovr_we = 0, mode_ovr_val = 0, reset_active = 1, mode_pin = 1;
  logic              hold_req_n = 1, float_n = 1, clk_en = 1;
  logic [1:0]        req_space = 0;
  logic [ADDR_W-1:0] req_addr = 0, addr_o;
  logic [DATA_W-1:0] req_wdata = 0, rsp_rdata, data_o, data_i;
  logic [WAIT_W-1:0] req_waits = 0;
  logic [3:0]        lo_len = 0;
  logic              req_ready, rsp_valid, rom_hit, rom_map_mode_sel, ready_in;
  logic              data_space_sel_n, program_space_sel_n, io_space_sel_n, sel_oe;
  logic              memory_strobe_n, io_device_strobe_n, rd_wr_n, ctl_oe;
  logic              bus_release_ack, ack_oe, addr_oe, data_oe, wait_states_done_n, msc_oe;
  logic [56:0]       q[$];
  logic [56:0]       e;
  int                cyc = 0, miscompares = 0, comparisons = 0, seed = 32'h4448;
  int                wt[4] = '{0, 1, 2, 5};
  int                lt[4] = '{3, 3, 2, 7};
  ebh_bus_if ebh_bus_if_i (.sys_clk, .rst_b, .clk_en, .req_valid, .req_ready, .req_space,
    .req_write, .req_addr, .req_wdata, .req_waits, .rsp_valid, .rsp_rdata, .rom_hit, .mode_ovr_we,
    .mode_ovr_val, .rom_map_mode_sel, .reset_active, .mode_pin, .ready_in, .hold_req_n, .float_n,
    .data_space_sel_n, .program_space_sel_n, .io_space_sel_n, .sel_oe, .memory_strobe_n,
    .io_device_strobe_n, .rd_wr_n, .ctl_oe, .bus_release_ack, .ack_oe, .addr_o, .addr_oe,
    .data_o, .data_oe, .data_i, .wait_states_done_n, .msc_oe);
  ebh_ext_mem ebh_ext_mem_i (.sys_clk, .memory_strobe_n, .io_device_strobe_n, .rd_wr_n, .addr_o,
    .lo_len, .ready_in, .data_i);
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc <= cyc + 1;
  task automatic chk(input logic [63:0] x, input logic [63:0] g);
    comparisons++;
    if (x !== g) begin
      miscompares++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, x, g);
    end
  endtask
  task automatic final_report;
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic acc(input logic [1:0] sp, input logic wr, input int w, input int lo);
    logic [ADDR_W-1:0] a;
    logic [DATA_W-1:0] d;
    int                n;
    int                k;
    a = $random(seed);
    d = $random(seed);
    n = 0;
    k = (w >= 2 && lo > w) ? lo - w : 0;
    @(posedge sys_clk);
    {req_space, req_write, req_addr, req_waits, lo_len} <= {sp, wr, a, 3'(w), 4'(lo)};
    req_wdata <= d;
    req_valid <= 1'b1;
    do @(posedge sys_clk); while (req_ready !== 1'b1 && ++n < 40);
    req_valid <= 1'b0;
    @(negedge sys_clk);
    q.push_back({32'(cyc), 8'(w + 1 + k), !wr, a[15:0] ^ 16'h5a5a});
    chk({~(3'b100 >> sp), sp == 2'h2, sp != 2'h2, !wr, w < 2, wr, sp == 2'h1 ? a : {4'h0, a[15:0]},
         d},
        {data_space_sel_n, program_space_sel_n, io_space_sel_n, memory_strobe_n, io_device_strobe_n,
         rd_wr_n, wait_states_done_n, data_oe, addr_o,
         data_o});
    n = 0;
    do @(posedge sys_clk); while (req_ready !== 1'b1 && ++n < 40);
  endtask
  // Latency of each completed access and read data of each completed read
  always @(negedge sys_clk) begin
    if (rsp_valid === 1'b1) begin
      e = q.pop_front();
      chk({e[24:17], e[15:0]}, {8'(cyc - e[56:25]), e[16] ? rsp_rdata : e[15:0]});
    end
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk) reset_active <= 1'b0;
    @(negedge sys_clk) chk(1, rom_map_mode_sel);
    for (int i = 0; i < 12; i++) acc(2'(i % 3), i[0] ^ i[2], wt[i / 3], lt[i / 3]);
    $display("access tests done");
    @(posedge sys_clk) hold_req_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    chk(6'h20, {bus_release_ack, sel_oe, ctl_oe, addr_oe, data_oe, req_ready});
    @(posedge sys_clk) hold_req_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk) chk(4'h7, {bus_release_ack, sel_oe, ctl_oe, addr_oe});
    @(posedge sys_clk) float_n <= 1'b0;
    @(negedge sys_clk) chk(0, {sel_oe, ctl_oe, addr_oe, ack_oe});
    @(posedge sys_clk) float_n <= 1'b1;
    $display("hold and float tests done");
    @(posedge sys_clk) mode_pin <= 1'b0;
    @(negedge sys_clk) chk(1, rom_map_mode_sel);
    @(posedge sys_clk) reset_active <= 1'b1;
    @(posedge sys_clk) reset_active <= 1'b0;
    {req_valid, req_space, req_addr} <= {1'b1, 2'h1, 20'h0f800};
    @(negedge sys_clk) chk(3'h3, {rom_map_mode_sel, rom_hit, memory_strobe_n});
    @(posedge sys_clk) req_valid <= 1'b0;
    {mode_ovr_we, mode_ovr_val} <= 2'h3;
    @(posedge sys_clk) mode_ovr_we <= 1'b0;
    @(negedge sys_clk) chk(1, rom_map_mode_sel);
    $display("mode tests done");
    @(posedge sys_clk) {clk_en, hold_req_n} <= 2'b00;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk) chk(0, bus_release_ack);
    @(posedge sys_clk) {clk_en, hold_req_n} <= 2'b11;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk) chk(0, bus_release_ack);
    $display("clock enable tests done");
    final_report();
  end
  initial begin
    #200000;
    miscompares++;
    final_report();
  end
endmodule
`default_nettype wire
